// [verilog/can_message_buffer_manager.sv]
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module can_message_buffer_manager (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin,
  output logic rx_bit,
  input wire logic tx_bit,
  input wire logic rx_start,
  input wire logic rx_byte_valid,
  input wire logic [can_buf_pkg::BYTE_IDX_W-1:0] rx_byte_index,
  input wire logic [7:0] rx_byte,
  input wire logic rx_done,
  input wire logic rx_hit,
  input wire logic tx_active,
  input wire logic arb_start,
  input wire logic arb_lost,
  input wire logic tx_done,
  input wire logic tx_fail,
  input wire logic [can_buf_pkg::BYTE_IDX_W-1:0] tx_rd_index,
  output logic [7:0] tx_rd_data,
  output logic tx_pending,
  output logic [1:0] tx_select,
  output logic ack_enable,
  output logic rx_irq,
  output logic err_irq,
  output logic tx_irq
);
  import can_buf_pkg::*;
  // =====================================
  // storage
  logic [7:0] background_receive_buffer [0:FRAME_BYTES-1];
  logic [7:0] foreground_receive_buffer [0:FRAME_BYTES-1];
  logic [7:0] tx_buf [0:NUM_TX-1][0:FRAME_BYTES-1];
  logic [LOCAL_PRIORITY_FIELD_W-1:0] local_priority_field [0:NUM_TX-1];
  logic loopback, rx_ie, ovr_ie, receive_full_flag, overrun_flag;
  logic bg_full, own_frame, tx_busy;
  logic [2:0] tx_ie, transmit_empty_flag, abort_request_flag, abort_acknowledge_flag;
  // =====================================
  // ahb-lite slave
  logic wr_pend, rd_pend, take;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0] rd_word;
  assign take = hsel & htrans[1] & hready;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= ZERO_WORD;
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
      if (rd_pend) begin
        rd_pend <= 1'b0;
        hrdata <= rd_word;
        hreadyout <= 1'b1;
      end else begin
        wr_pend <= take & hwrite;
        rd_pend <= take & ~hwrite;
        hreadyout <= ~(take & ~hwrite);
        if (take) begin
          addr_q <= haddr[ADDR_W-1:0];
        end
      end
    end
  end
  logic wr_ctrl, wr_rflg, wr_tflg, wr_tctrl, wr_local_priority_field;
  assign wr_ctrl = wr_pend && addr_q == ADDR_CTRL;
  assign wr_rflg = wr_pend && addr_q == ADDR_RX_FLAGS;
  assign wr_tflg = wr_pend && addr_q == ADDR_TX_FLAGS;
  assign wr_tctrl = wr_pend && addr_q == ADDR_TX_CTRL;
  assign wr_local_priority_field = wr_pend && addr_q == ADDR_TX_LOCAL_PRIORITY_FIELD;
  function automatic logic [31:0] pack_word(input logic [7:0] b [0:FRAME_BYTES-1],
                                            input logic [1:0] w);
    logic [31:0] r;
    int k;
    r = ZERO_WORD;
    for (int l = 0; l < 4; l++) begin
      k = 4 * int'(w) + l;
      if (k < FRAME_BYTES) begin
        r[8*l +: 8] = b[k];
      end
    end
    return r;
  endfunction
  // =====================================
  // read mux, unmapped reads return zero
  always_comb begin
    rd_word = ZERO_WORD;
    case (addr_q)
      ADDR_CTRL: begin
        rd_word[CTRL_LOOPBACK] = loopback;
        rd_word[CTRL_RX_IE] = rx_ie;
        rd_word[CTRL_OVR_IE] = ovr_ie;
        rd_word[CTRL_TX_IE +: 3] = tx_ie;
      end
      ADDR_RX_FLAGS: begin
        rd_word[RFLG_RXF] = receive_full_flag;
        rd_word[RFLG_OVR] = overrun_flag;
      end
      ADDR_TX_FLAGS: begin
        rd_word[TFLG_TXE +: 3] = transmit_empty_flag;
        rd_word[TFLG_ABORT_ACKNOWLEDGE_FLAG +: 3] = abort_acknowledge_flag;
      end
      ADDR_TX_CTRL: rd_word[2:0] = abort_request_flag;
      ADDR_TX_LOCAL_PRIORITY_FIELD: rd_word[23:0] = {local_priority_field[2], local_priority_field[1],
                                     local_priority_field[0]};
      default: begin
        if (addr_q[7:4] == WIN_RX_FG) begin
          rd_word = pack_word(foreground_receive_buffer, addr_q[3:2]);
        end else if (addr_q[7:4] >= WIN_TX0 && addr_q[7:4] < WIN_TX0 + 4'h3) begin
          rd_word = pack_word(tx_buf[2'(addr_q[7:4] - WIN_TX0)], addr_q[3:2]);
        end
      end
    endcase
  end
  // =====================================
  // control register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      loopback <= 1'b0;
      rx_ie <= 1'b0;
      ovr_ie <= 1'b0;
      tx_ie <= 3'h0;
    end else if (wr_ctrl) begin
      loopback <= hwdata[CTRL_LOOPBACK];
      rx_ie <= hwdata[CTRL_RX_IE];
      ovr_ie <= hwdata[CTRL_OVR_IE];
      tx_ie <= hwdata[CTRL_TX_IE +: 3];
    end
  end
  // =====================================
  // pins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus_transmit_pin <= 1'b1;
      rx_bit <= 1'b1;
    end else begin
      bus_transmit_pin <= tx_bit;
      rx_bit <= bus_receive_pin;
    end
  end
  // =====================================
  // receive fifo
  logic own_drop, frame_in, copy_now;
  assign own_drop = own_frame & ~loopback;
  assign frame_in = rx_done & rx_hit & ~own_drop;
  assign copy_now = ~receive_full_flag & (frame_in | bg_full);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      own_frame <= 1'b0;
    end else if (arb_lost) begin
      own_frame <= 1'b0;
    end else if (rx_start) begin
      own_frame <= tx_active;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rx_byte_valid && !bg_full && rx_byte_index < BYTE_IDX_W'(FRAME_BYTES)) begin
      background_receive_buffer[rx_byte_index] <= rx_byte;
    end
    if (copy_now) begin
      foreground_receive_buffer <= background_receive_buffer;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bg_full <= 1'b0;
    end else if (frame_in && !bg_full && receive_full_flag) begin
      bg_full <= 1'b1;
    end else if (bg_full && !receive_full_flag) begin
      bg_full <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      receive_full_flag <= 1'b0;
    end else if (copy_now) begin
      receive_full_flag <= 1'b1;
    end else if (wr_rflg && hwdata[RFLG_RXF]) begin
      receive_full_flag <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      overrun_flag <= 1'b0;
    end else if (frame_in && bg_full) begin
      overrun_flag <= 1'b1;
    end else if (wr_rflg && hwdata[RFLG_OVR]) begin
      overrun_flag <= 1'b0;
    end
  end
  // =====================================
  // transmit buffers and priorities
  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < NUM_TX; b++) begin
      for (int l = 0; l < 4; l++) begin
        if (wr_pend && addr_q[7:4] == WIN_TX0 + 4'(b) &&
            4 * int'(addr_q[3:2]) + l < FRAME_BYTES) begin
          tx_buf[b][4 * int'(addr_q[3:2]) + l] <= hwdata[8*l +: 8];
        end
      end
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int b = 0; b < NUM_TX; b++) begin
        local_priority_field[b] <= LOCAL_PRIORITY_FIELD_RESET;
      end
    end else if (wr_local_priority_field) begin
      for (int b = 0; b < NUM_TX; b++) begin
        local_priority_field[b] <= hwdata[8*b +: 8];
      end
    end
  end
  // =====================================
  // scheduler
  logic [2:0] ready;
  logic have_ready;
  logic [1:0] best;
  logic [LOCAL_PRIORITY_FIELD_W-1:0] best_p;
  assign ready = ~transmit_empty_flag;
  assign have_ready = |ready;
  always_comb begin
    best = 2'd0;
    best_p = local_priority_field[0];
    for (int b = NUM_TX - 1; b >= 0; b--) begin
      if (ready[b] && (!ready[best] || best == 2'(b) ||
          local_priority_field[b] <= best_p)) begin
        best = 2'(b);
        best_p = local_priority_field[b];
      end
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_busy <= 1'b0;
      tx_select <= 2'd0;
    end else if (arb_start && have_ready) begin
      tx_busy <= 1'b1;
      tx_select <= best;
    end else if (tx_done || tx_fail || arb_lost) begin
      tx_busy <= 1'b0;
    end
  end
  logic [2:0] abort_now, sent_now;
  always_comb begin
    for (int b = 0; b < NUM_TX; b++) begin
      sent_now[b] = tx_done && tx_busy && tx_select == 2'(b);
      abort_now[b] = abort_request_flag[b] && ready[b] &&
                     !(tx_busy && tx_select == 2'(b)) &&
                     !(arb_start && best == 2'(b));
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      transmit_empty_flag <= TXE_RESET;
      abort_request_flag <= 3'h0;
      abort_acknowledge_flag <= 3'h0;
    end else begin
      for (int b = 0; b < NUM_TX; b++) begin
        if (sent_now[b] || abort_now[b]) begin
          transmit_empty_flag[b] <= 1'b1;
          abort_request_flag[b] <= 1'b0;
        end else begin
          if (wr_tflg && hwdata[TFLG_TXE + b]) begin
            transmit_empty_flag[b] <= 1'b0;
          end
          if (wr_tctrl && hwdata[b]) begin
            abort_request_flag[b] <= 1'b1;
          end
        end
        if (abort_now[b]) begin
          abort_acknowledge_flag[b] <= 1'b1;
        end else if (wr_tflg && (hwdata[TFLG_ABORT_ACKNOWLEDGE_FLAG + b] || hwdata[TFLG_TXE + b])) begin
          abort_acknowledge_flag[b] <= 1'b0;
        end
      end
    end
  end
  // =====================================
  // engine side outputs and interrupt levels
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_rd_data <= 8'h00;
      tx_pending <= 1'b0;
      ack_enable <= 1'b1;
      rx_irq <= 1'b0;
      err_irq <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      tx_rd_data <= (tx_rd_index < BYTE_IDX_W'(FRAME_BYTES) && tx_select < 2'd3) ?
                    tx_buf[tx_select][tx_rd_index] : 8'h00;
      tx_pending <= have_ready;
      ack_enable <= ~own_drop;
      rx_irq <= receive_full_flag & rx_ie;
      err_irq <= overrun_flag & ovr_ie;
      tx_irq <= |(transmit_empty_flag & tx_ie);
    end
  end
endmodule

// [verilog/can_buf_pkg.sv]
package can_buf_pkg;
  // =====================================
  // buffer geometry
  localparam int FRAME_BYTES = 13;
  localparam int NUM_TX = 3;
  localparam int LOCAL_PRIORITY_FIELD_W = 8;
  localparam int BYTE_IDX_W = 4;
  localparam int ADDR_W = 8;
  // =====================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RX_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_TX_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_TX_LOCAL_PRIORITY_FIELD = 8'h10;
  // buffer windows: upper nibble selects, [3:2] selects the word
  localparam logic [3:0] WIN_RX_FG = 4'h4;
  localparam logic [3:0] WIN_TX0 = 4'h5;
  // =====================================
  // field positions
  localparam int CTRL_LOOPBACK = 0;
  localparam int CTRL_RX_IE = 1;
  localparam int CTRL_OVR_IE = 2;
  localparam int CTRL_TX_IE = 4;
  localparam int RFLG_RXF = 0;
  localparam int RFLG_OVR = 1;
  localparam int TFLG_TXE = 0;
  localparam int TFLG_ABORT_ACKNOWLEDGE_FLAG = 4;
  // =====================================
  // reset values
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [2:0] TXE_RESET = 3'h7;
  localparam logic [7:0] LOCAL_PRIORITY_FIELD_RESET = 8'h00;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

// [bench/can_buf_checker_assertions.sv]
`timescale 1ns/1ps
module can_buf_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] hresp,
  input wire logic bus_transmit_pin,
  input wire logic tx_bit,
  input wire logic rx_bit,
  input wire logic bus_receive_pin,
  input wire logic [can_buf_pkg::BYTE_IDX_W-1:0] tx_rd_index,
  input wire logic [7:0] tx_rd_data,
  input wire logic arb_start,
  input wire logic [1:0] tx_select
);
  import can_buf_pkg::*;
  // ==========================================
  // bus, pin and engine side checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire take = hsel && htrans[1] && hready;
  chk_tx_pin_copy: assert property (!$past(reset) |-> bus_transmit_pin == $past(tx_bit))
    else $error("transmit pin does not follow tx bit");
  chk_rx_bit_copy: assert property (!$past(reset) |-> rx_bit == $past(bus_receive_pin))
    else $error("rx bit does not follow receive pin");
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("response not okay");
  chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved without a read");
  chk_rd_idx_zero: assert property (tx_rd_index > 4'hc |=> tx_rd_data == 8'h00)
    else $error("byte past frame not zero");
  chk_sel_hold: assert property (!arb_start |=> $stable(tx_select))
    else $error("selection changed without arbitration");
  chk_sel_range: assert property (tx_select != 2'h3)
    else $error("selection out of range");
endmodule
bind can_message_buffer_manager can_buf_checker chk (.*);

// [bench/can_bus_node.sv]
`timescale 1ns/1ps
module can_bus_node (
  input wire logic tx_pin,
  input wire logic node_bit,
  output logic bus_level
);
  // wired bus: a dominant 0 from any node wins
  assign bus_level = tx_pin & node_bit;
endmodule

// [bench/can_message_buffer_manager_tb.sv]
`timescale 1ns/1ps
module can_message_buffer_manager_tb;
  import can_buf_pkg::*;
  logic ref_clk, reset, hsel, hwrite, tx_bit, rx_start, rx_byte_valid, rx_done, rx_hit;
  logic tx_active, arb_lost, node_bit, hreadyout, bus_receive_pin, bus_transmit_pin, rx_bit;
  logic tx_pending, ack_enable, rx_irq, err_irq, tx_irq, arb_start, tx_done, tx_fail;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, hresp, tx_select;
  logic [2:0] hsize, evt;
  logic [3:0] rx_byte_index, tx_rd_index;
  logic [7:0] rx_byte, tx_rd_data;
  int bad_count, compares;
  wire hready = hreadyout;
  assign {arb_start, tx_done, tx_fail} = evt;
  can_message_buffer_manager DUT (.*);
  can_bus_node node (.tx_pin(bus_transmit_pin), .node_bit(node_bit), .bus_level(bus_receive_pin));
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================
  // shared tasks
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rck(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, ZERO_WORD);
    check(n, rd, e);
  endtask
  task automatic ev(input logic [2:0] e);
    evt <= e;
    cyc(1);
    evt <= 3'h0;
    cyc(2);
  endtask
  task automatic frame(input logic own, hit, lost, ack, input logic [7:0] k);
    int i;
    tx_active <= own;
    rx_start <= 1'b1;
    cyc(1);
    rx_start <= 1'b0;
    rx_byte_valid <= 1'b1;
    for (i = 0; i < 13; i++) begin
      rx_byte_index <= i[3:0];
      rx_byte <= k + i[7:0];
      arb_lost <= (i == 2) && lost;
      if (i == 5) check("ack enable", 32'(ack_enable), 32'(ack));
      cyc(1);
    end
    rx_byte_valid <= 1'b0;
    rx_done <= 1'b1;
    rx_hit <= hit;
    cyc(1);
    rx_done <= 1'b0;
    tx_active <= 1'b0;
    cyc(3);
  endtask
  task automatic test_done;
    $display("compares %0d, bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic test_reset;
    check("idle pin", 32'(bus_transmit_pin), 32'h1);
    rck("tx flags", ADDR_TX_FLAGS, 32'(TXE_RESET));
    rck("rx flags", ADDR_RX_FLAGS, ZERO_WORD);
    rck("local_priority_field", ADDR_TX_LOCAL_PRIORITY_FIELD, ZERO_WORD);
    rck("unmapped", 8'h30, ZERO_WORD);
    $display("test_reset done");
  endtask
  task automatic test_pins;
    node_bit <= 1'b0;
    cyc(3);
    check("rx bit", 32'(rx_bit), 32'h0);
    node_bit <= 1'b1;
    tx_bit <= 1'b0;
    cyc(3);
    check("tx pin", 32'(bus_transmit_pin), 32'h0);
    check("rx dominant", 32'(rx_bit), 32'h0);
    tx_bit <= 1'b1;
    cyc(3);
    check("rx recessive", 32'(rx_bit), 32'h1);
    $display("test_pins done");
  endtask
  task automatic test_rx;
    wr(ADDR_CTRL, 32'h0000_0006);
    frame(1'b0, 1'b1, 1'b0, 1'b1, 8'h10);
    rck("rxf", ADDR_RX_FLAGS, 32'h0000_0001);
    check("rx irq", 32'(rx_irq), 32'h1);
    rck("fg word0", 8'h40, 32'h1312_1110);
    rck("fg word3", 8'h4c, 32'h0000_001c);
    frame(1'b0, 1'b0, 1'b0, 1'b1, 8'h20);
    frame(1'b0, 1'b1, 1'b0, 1'b1, 8'h30);
    frame(1'b0, 1'b1, 1'b0, 1'b1, 8'h40);
    rck("overrun", ADDR_RX_FLAGS, 32'h0000_0003);
    check("err irq", 32'(err_irq), 32'h1);
    wr(ADDR_TX_FLAGS, 32'h0000_0001);
    cyc(2);
    check("pending", 32'(tx_pending), 32'h1);
    ev(3'h4);
    ev(3'h2);
    rck("sent while full", ADDR_TX_FLAGS, 32'h0000_0007);
    check("idle pending", 32'(tx_pending), 32'h0);
    rck("still full", ADDR_RX_FLAGS, 32'h0000_0003);
    wr(ADDR_RX_FLAGS, 32'h0000_0003);
    cyc(2);
    rck("refill", ADDR_RX_FLAGS, 32'h0000_0001);
    rck("fg next", 8'h40, 32'h3332_3130);
    wr(ADDR_RX_FLAGS, 32'h0000_0001);
    rck("rx empty", ADDR_RX_FLAGS, ZERO_WORD);
    $display("test_rx done");
  endtask
  task automatic test_own;
    frame(1'b1, 1'b1, 1'b0, 1'b0, 8'h50);
    rck("own kept out", ADDR_RX_FLAGS, ZERO_WORD);
    check("own irq", 32'(rx_irq), 32'h0);
    frame(1'b1, 1'b1, 1'b1, 1'b1, 8'h58);
    rck("lost arb", 8'h40, 32'h5b5a_5958);
    wr(ADDR_RX_FLAGS, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0007);
    frame(1'b1, 1'b1, 1'b0, 1'b1, 8'h60);
    rck("loopback", ADDR_RX_FLAGS, 32'h0000_0001);
    wr(ADDR_RX_FLAGS, 32'h0000_0001);
    $display("test_own done");
  endtask
  task automatic test_tx;
    wr(8'h50, 32'h4433_2211);
    tx_rd_index <= 4'h1;
    cyc(2);
    check("tx byte", 32'(tx_rd_data), 32'h22);
    wr(ADDR_TX_LOCAL_PRIORITY_FIELD, 32'h0005_0303);
    wr(ADDR_CTRL, 32'h0000_0076);
    wr(ADDR_TX_FLAGS, 32'h0000_0007);
    ev(3'h4);
    check("tie", 32'(tx_select), 32'h0);
    ev(3'h2);
    rck("sent", ADDR_TX_FLAGS, 32'h0000_0001);
    check("tx irq", 32'(tx_irq), 32'h1);
    ev(3'h4);
    check("next", 32'(tx_select), 32'h1);
    ev(3'h1);
    wr(ADDR_TX_LOCAL_PRIORITY_FIELD, 32'h0001_0303);
    ev(3'h4);
    check("retry", 32'(tx_select), 32'h2);
    ev(3'h2);
    ev(3'h4);
    ev(3'h2);
    rck("all sent", ADDR_TX_FLAGS, 32'h0000_0007);
    $display("test_tx done");
  endtask
  task automatic test_abort;
    wr(ADDR_TX_FLAGS, 32'h0000_0001);
    wr(ADDR_TX_CTRL, 32'h0000_0001);
    cyc(2);
    rck("aborted", ADDR_TX_FLAGS, 32'h0000_0017);
    rck("req cleared", ADDR_TX_CTRL, ZERO_WORD);
    wr(ADDR_TX_FLAGS, 32'h0000_0002);
    ev(3'h4);
    wr(ADDR_TX_CTRL, 32'h0000_0002);
    cyc(2);
    rck("busy kept", ADDR_TX_FLAGS, 32'h0000_0015);
    ev(3'h2);
    rck("sent anyway", ADDR_TX_FLAGS, 32'h0000_0017);
    rck("req done", ADDR_TX_CTRL, ZERO_WORD);
    $display("test_abort done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = ZERO_WORD;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = ZERO_WORD;
    tx_bit = 1'b1;
    node_bit = 1'b1;
    rx_start = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte_index = 4'h0;
    rx_byte = 8'h00;
    rx_done = 1'b0;
    rx_hit = 1'b0;
    tx_active = 1'b0;
    arb_lost = 1'b0;
    evt = 3'h0;
    tx_rd_index = 4'hd;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    cyc(1);
    test_reset();
    test_pins();
    test_rx();
    test_own();
    test_tx();
    test_abort();
    test_done();
  end
  initial begin
    #(25 * 20000);
    bad_count++;
    test_done();
  end
endmodule
